// ===== core/sp_serial_port.sv
// Three-mode serial port with an AXI4-Lite register slave.
// Assumes one 20 MHz clock, a one-cycle timer overflow pulse, and that the
// testbench resolves the two-way data line from rxd_oe.
//
// Contract
// - Buffer writes transmit, buffer reads return received byte.
// - Sync mode: data on rxd, clock on txd.
// - Sync rate osc/12 or osc/4 by speed bit.
// - Fast sync: data 1 clock early, low 2.
// - Slow sync: data 3 clocks early, low 6.
// - Sync transmit-done set after last bit ends.
// - Sync receive starts on enable and flag clear.
// - Sync receive-done after last rise; blocks further reception.
// - Ten-bit frame; stop bit stored as ninth.
// - Ten-bit rate is timer overflow /16 or /32.
// - Async bits follow divide-by-16 rollovers.
// - Ten-bit transmit-done at tenth rollover.
// - Hunt falling edge at 16x; reset counter.
// - Bits decided by majority of three samples.
// - Non-zero start bit aborts reception.
// - Load only if flag clear and multiproc allows.
// - Resume hunting after stop bit middle.
// - Eleven-bit frame with programmable ninth bit.
// - Eleven-bit rate osc/32 or osc/64.
// - Eleven-bit transmit-done at eleventh rollover.
// - No async reception while receive disabled; a frame already started when it is cleared still completes and loads.
module sp_serial_port
	import sp_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [SP_ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [SP_ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic timer1_overflow,
	input wire logic rxd_in,
	output logic rxd_out,
	output logic rxd_oe,
	output logic txd
);

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Software visible state.
	sp_mode_t mode_reg;
	logic speed_or_multiproc_bit_reg;
	logic receive_enable_reg;
	logic transmit_ninth_bit_reg;
	logic received_ninth_bit_reg;
	logic transmit_done_flag_reg;
	logic receive_done_flag_reg;
	logic double_rate_bit_reg;
	logic [7:0] serial_buffer_reg;

	// Bus slave state.
	logic aw_held_reg;
	logic w_held_reg;
	logic [SP_ADDR_W-1:0] awaddr_reg;
	logic [7:0] wbyte_reg;
	logic wlane_reg;

	// Engine state.
	sp_tx_state_t state_reg;
	logic [10:0] shift_reg;
	logic [3:0] phase_reg;
	logic [3:0] count_reg;
	logic [3:0] div16_reg;
	logic [2:0] m2_div_reg;
	logic ovf_half_reg;

	// Receiver outputs.
	logic rx_done;
	logic [7:0] rx_data;
	logic rx_ninth;
	logic rx_stop;

	// Write decode: a write fires once address and data are both held.
	wire logic do_write = aw_held_reg && w_held_reg && !bvalid;
	wire logic wr_hit_buffer = awaddr_reg == SP_OFS_BUFFER;
	wire logic wr_hit_control = awaddr_reg == SP_OFS_CONTROL;
	wire logic wr_hit_power = awaddr_reg == SP_OFS_POWER;
	wire logic wr_mapped = wr_hit_buffer || wr_hit_control || wr_hit_power;
	wire logic wr_buffer = do_write && wr_hit_buffer && wlane_reg;
	wire logic wr_control = do_write && wr_hit_control && wlane_reg;
	wire logic wr_power = do_write && wr_hit_power && wlane_reg;

	// Read decode; the buffer read path sees only the receive side.
	wire logic rd_take = arvalid && arready;
	wire logic [7:0] ctrl_view = {receive_done_flag_reg, transmit_done_flag_reg,
		received_ninth_bit_reg, transmit_ninth_bit_reg, receive_enable_reg,
		speed_or_multiproc_bit_reg, mode_reg};
	wire logic rd_hit_buffer = araddr == SP_OFS_BUFFER;
	wire logic rd_hit_control = araddr == SP_OFS_CONTROL;
	wire logic rd_hit_power = araddr == SP_OFS_POWER;
	wire logic rd_mapped = rd_hit_buffer || rd_hit_control || rd_hit_power;
	wire logic [7:0] rd_byte = rd_hit_buffer ? serial_buffer_reg :
		rd_hit_control ? ctrl_view :
		rd_hit_power ? {7'h00, double_rate_bit_reg} : 8'h00;

	// Handshake outputs: one write and one read in flight at most.
	assign awready = !aw_held_reg;
	assign wready = !w_held_reg;
	assign arready = !rvalid;

	// Mode decode.
	wire logic is_sync = mode_reg == SP_MODE_SYNC;
	wire logic is_ten = mode_reg == SP_MODE_ASYNC_TEN;
	wire logic is_eleven = mode_reg == SP_MODE_ASYNC_ELEVEN;

	// Synchronous shift clock shape; the speed bit picks the fast or slow form.
	wire logic [3:0] m0_period = speed_or_multiproc_bit_reg ? SP_M0_PERIOD_FAST :
		SP_M0_PERIOD_SLOW;
	wire logic [3:0] m0_fall = speed_or_multiproc_bit_reg ? SP_M0_LEAD_FAST :
		SP_M0_LEAD_SLOW;
	wire logic [3:0] m0_rise = speed_or_multiproc_bit_reg ?
		SP_M0_LEAD_FAST + SP_M0_LOW_FAST : SP_M0_LEAD_SLOW + SP_M0_LOW_SLOW;
	wire logic m0_active = (state_reg == SP_ST_SYNC_TX) || (state_reg == SP_ST_SYNC_RX);
	wire logic m0_period_end = m0_active && (phase_reg == m0_period - 4'h1);
	wire logic m0_rise_now = m0_active && (phase_reg == m0_rise);
	wire logic m0_last_bit = count_reg == SP_M0_BITS - 4'h1;

	// Oversampling tick: the timer overflow halved unless double rate is set
	// in the ten-bit mode, a plain clock divider in the eleven-bit mode.
	wire logic [2:0] m2_div = double_rate_bit_reg ? SP_M2_DIV_FAST : SP_M2_DIV_SLOW;
	wire logic m2_tick = m2_div_reg == m2_div - 3'h1;
	wire logic t1_tick = timer1_overflow && (double_rate_bit_reg || ovf_half_reg);
	wire logic tick16 = (is_ten && t1_tick) || (is_eleven && m2_tick);
	wire logic rollover = tick16 && (div16_reg == SP_DIV16_LAST);

	// Transmit start and its frame; unsupported mode value keeps the port idle.
	wire logic idle = state_reg == SP_ST_IDLE;
	wire logic tx_start = wr_buffer && idle && (mode_reg != SP_MODE_SPARE);
	wire logic [3:0] frame_len = is_eleven ? SP_FRAME_ELEVEN : SP_FRAME_TEN;
	wire logic ninth_out = is_eleven ? transmit_ninth_bit_reg : 1'b1;
	wire logic async_last = count_reg == frame_len - 4'h1;
	wire logic m0_rx_start = is_sync && idle && !wr_buffer && receive_enable_reg &&
		!receive_done_flag_reg;

	// Flag events from the engines.
	wire logic ti_set = (state_reg == SP_ST_SYNC_TX && m0_period_end && m0_last_bit) ||
		(state_reg == SP_ST_ASYNC_TX && rollover && async_last);
	wire logic m0_rx_done = state_reg == SP_ST_SYNC_RX && m0_rise_now && m0_last_bit;
	wire logic rx_accept = rx_done && !receive_done_flag_reg &&
		(!speed_or_multiproc_bit_reg || rx_stop);
	wire logic ri_set = m0_rx_done || rx_accept;

	// Asynchronous receiver, only live in the two asynchronous modes.
	sp_async_rx u_rx (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick16(tick16),
		.enable(receive_enable_reg && (is_ten || is_eleven)),
		.eleven_bit(is_eleven),
		.rxd(rxd_in),
		.frame_done(rx_done),
		.frame_data(rx_data),
		.frame_ninth(rx_ninth),
		.frame_stop(rx_stop)
	);

	// Write channel capture; address and data may arrive in either order.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= '0;
			wbyte_reg <= 8'h00;
			wlane_reg <= 1'b0;
		end else begin
			if (awvalid && awready) begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= awaddr;
			end else if (do_write) begin
				aw_held_reg <= 1'b0;
			end
			if (wvalid && wready) begin
				w_held_reg <= 1'b1;
				wbyte_reg <= wdata[7:0];
				wlane_reg <= wstrb[0];
			end else if (do_write) begin
				w_held_reg <= 1'b0;
			end
		end
	end

	// Responses; an unmapped address answers SLVERR and reads as zero.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			rvalid <= 1'b0;
			rresp <= RESP_OKAY;
			rdata <= 32'h0000_0000;
		end else begin
			if (do_write) begin
				bvalid <= 1'b1;
				bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
			if (rd_take) begin
				rvalid <= 1'b1;
				rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
				rdata <= {24'h00_0000, rd_byte};
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// Control fields. Flags: a hardware set in the same cycle as a software
	// write wins, so no completion is ever lost to a racing clear.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_reg <= sp_mode_t'(SP_CTRL_RESET[SP_CTRL_MODE_LSB +: 2]);
			speed_or_multiproc_bit_reg <= SP_CTRL_RESET[SP_CTRL_SPEED];
			receive_enable_reg <= SP_CTRL_RESET[SP_CTRL_RX_EN];
			transmit_ninth_bit_reg <= SP_CTRL_RESET[SP_CTRL_TX_NINTH];
			transmit_done_flag_reg <= SP_CTRL_RESET[SP_CTRL_TX_DONE];
			receive_done_flag_reg <= SP_CTRL_RESET[SP_CTRL_RX_DONE];
			double_rate_bit_reg <= SP_POWER_RESET[SP_POWER_DOUBLE];
		end else begin
			if (wr_control) begin
				mode_reg <= sp_mode_t'(wbyte_reg[SP_CTRL_MODE_LSB +: 2]);
				speed_or_multiproc_bit_reg <= wbyte_reg[SP_CTRL_SPEED];
				receive_enable_reg <= wbyte_reg[SP_CTRL_RX_EN];
				transmit_ninth_bit_reg <= wbyte_reg[SP_CTRL_TX_NINTH];
			end
			if (ti_set)
				transmit_done_flag_reg <= 1'b1;
			else if (wr_control)
				transmit_done_flag_reg <= wbyte_reg[SP_CTRL_TX_DONE];
			if (ri_set)
				receive_done_flag_reg <= 1'b1;
			else if (wr_control)
				receive_done_flag_reg <= wbyte_reg[SP_CTRL_RX_DONE];
			if (wr_power)
				double_rate_bit_reg <= wbyte_reg[SP_POWER_DOUBLE];
		end
	end

	// Receive buffer and received ninth bit are loaded only by completed frames.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			serial_buffer_reg <= SP_BUFFER_RESET;
			received_ninth_bit_reg <= SP_CTRL_RESET[SP_CTRL_RX_NINTH];
		end else if (m0_rx_done) begin
			serial_buffer_reg <= {rxd_in, shift_reg[7:1]};
		end else if (rx_accept) begin
			serial_buffer_reg <= rx_data;
			received_ninth_bit_reg <= is_eleven ? rx_ninth : rx_stop;
		end
	end

	// Rate dividers. The divide-by-16 counter free-runs so transmit timing is
	// tied to it rather than to the buffer write.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			m2_div_reg <= 3'h0;
			ovf_half_reg <= 1'b0;
			div16_reg <= 4'h0;
		end else begin
			m2_div_reg <= m2_tick ? 3'h0 : m2_div_reg + 3'h1;
			if (timer1_overflow)
				ovf_half_reg <= !ovf_half_reg;
			if (tick16)
				div16_reg <= div16_reg + 4'h1;
		end
	end

	// Transmit and synchronous engine state.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= SP_ST_IDLE;
			phase_reg <= 4'h0;
			count_reg <= 4'h0;
		end else begin
			case (state_reg)
				SP_ST_IDLE: begin
					phase_reg <= 4'h0;
					count_reg <= 4'h0;
					if (tx_start)
						state_reg <= is_sync ? SP_ST_SYNC_TX : SP_ST_ASYNC_TX;
					else if (m0_rx_start)
						state_reg <= SP_ST_SYNC_RX;
				end
				SP_ST_SYNC_TX, SP_ST_SYNC_RX: begin
					phase_reg <= m0_period_end ? 4'h0 : phase_reg + 4'h1;
					if (m0_period_end)
						count_reg <= count_reg + 4'h1;
					if (ti_set || m0_rx_done)
						state_reg <= SP_ST_IDLE; // Eight bits per frame.
				end
				SP_ST_ASYNC_TX: begin
					if (rollover) begin
						count_reg <= count_reg + 4'h1;
						if (async_last)
							state_reg <= SP_ST_IDLE;
					end
				end
				default: state_reg <= SP_ST_IDLE;
			endcase
		end
	end

	// Shift register: loaded on start, shifted out per bit, or filled from the
	// line in synchronous receive. Idle fill is ones so the line rests high.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shift_reg <= 11'h7ff;
		end else if (tx_start) begin
			shift_reg <= is_sync ? {3'h7, wbyte_reg} :
				{1'b1, ninth_out, wbyte_reg, 1'b0};
		end else if (state_reg == SP_ST_SYNC_TX && m0_period_end) begin
			shift_reg <= {1'b1, shift_reg[10:1]}; // Least significant first.
		end else if (state_reg == SP_ST_SYNC_RX && m0_rise_now) begin
			shift_reg <= {3'h7, rxd_in, shift_reg[7:1]}; // Sample on rise.
		end else if (state_reg == SP_ST_ASYNC_TX && rollover) begin
			shift_reg <= {1'b1, shift_reg[10:1]};
		end
	end

	// Pin drivers. In sync mode txd carries the shift clock; in async modes a
	// bit changes only on a rollover, which is what keeps bit cells equal.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			txd <= 1'b1;
			rxd_out <= 1'b1;
			rxd_oe <= 1'b0;
		end else begin
			if (m0_active && phase_reg == m0_fall && !(ti_set || m0_rx_done))
				txd <= 1'b0;
			else if (m0_active && phase_reg == m0_rise)
				txd <= 1'b1;
			else if (state_reg == SP_ST_ASYNC_TX && rollover)
				txd <= shift_reg[0];
			else if (!m0_active && state_reg != SP_ST_ASYNC_TX)
				txd <= 1'b1;
			if (state_reg == SP_ST_SYNC_TX) begin // Last bit outlives its rise by one clock fast, three clocks slow.
				rxd_oe <= 1'b1;
				if (phase_reg == 4'h0)
					rxd_out <= shift_reg[0]; // Data leads the falling edge.
			end else begin
				rxd_oe <= 1'b0;
				rxd_out <= 1'b1;
			end
		end
	end

endmodule

// ===== core/sp_pkg.sv
// Shared constants and types of the three-mode serial port.
// Assumes a single 20 MHz system clock; every slower rate is an enable pulse.
package sp_pkg;

	// Register byte offsets on the AXI4-Lite slave.
	localparam int unsigned SP_ADDR_W = 4;
	localparam logic [3:0] SP_OFS_BUFFER = 4'h0;
	localparam logic [3:0] SP_OFS_CONTROL = 4'h4;
	localparam logic [3:0] SP_OFS_POWER = 4'h8;

	// Field positions inside the serial control register.
	localparam int unsigned SP_CTRL_MODE_LSB = 0;
	localparam int unsigned SP_CTRL_SPEED = 2;
	localparam int unsigned SP_CTRL_RX_EN = 3;
	localparam int unsigned SP_CTRL_TX_NINTH = 4;
	localparam int unsigned SP_CTRL_RX_NINTH = 5;
	localparam int unsigned SP_CTRL_TX_DONE = 6;
	localparam int unsigned SP_CTRL_RX_DONE = 7;
	localparam int unsigned SP_POWER_DOUBLE = 0;

	// Reset values.
	localparam logic [7:0] SP_CTRL_RESET = 8'h00;
	localparam logic [7:0] SP_POWER_RESET = 8'h00;
	localparam logic [7:0] SP_BUFFER_RESET = 8'h00;

	// Synchronous mode timing in clocks: period, data lead before fall, low time.
	localparam logic [3:0] SP_M0_PERIOD_SLOW = 4'hc;
	localparam logic [3:0] SP_M0_LEAD_SLOW = 4'h3;
	localparam logic [3:0] SP_M0_LOW_SLOW = 4'h6;
	localparam logic [3:0] SP_M0_PERIOD_FAST = 4'h4;
	localparam logic [3:0] SP_M0_LEAD_FAST = 4'h1;
	localparam logic [3:0] SP_M0_LOW_FAST = 4'h2;
	localparam logic [3:0] SP_M0_BITS = 4'h8;

	// Oversampling tick spacing in clocks for the fixed-rate eleven-bit mode.
	localparam logic [2:0] SP_M2_DIV_SLOW = 3'h4;
	localparam logic [2:0] SP_M2_DIV_FAST = 3'h2;

	// Divide-by-16 counter states and the three sampling states.
	localparam logic [3:0] SP_DIV16_LAST = 4'hf;
	localparam logic [3:0] SP_SAMPLE_A = 4'h7;
	localparam logic [3:0] SP_SAMPLE_B = 4'h8;
	localparam logic [3:0] SP_SAMPLE_C = 4'h9;

	// Frame lengths in bits, start and stop included.
	localparam logic [3:0] SP_FRAME_TEN = 4'ha;
	localparam logic [3:0] SP_FRAME_ELEVEN = 4'hb;

	typedef enum logic [1:0] {
		SP_MODE_SYNC = 2'h0,
		SP_MODE_ASYNC_TEN = 2'h1,
		SP_MODE_ASYNC_ELEVEN = 2'h2,
		SP_MODE_SPARE = 2'h3
	} sp_mode_t;

	typedef enum logic [1:0] {
		SP_ST_IDLE = 2'b00,
		SP_ST_SYNC_TX = 2'b01,
		SP_ST_SYNC_RX = 2'b11,
		SP_ST_ASYNC_TX = 2'b10
	} sp_tx_state_t;

	typedef enum logic {
		SP_RX_HUNT = 1'b0,
		SP_RX_FRAME = 1'b1
	} sp_rx_state_t;

	// Two-of-three majority vote.
	function automatic logic sp_majority(input logic a, input logic b, input logic c);
		sp_majority = (a & b) | (a & c) | (b & c);
	endfunction

endpackage

// ===== core/sp_async_rx.sv
// Asynchronous receiver with 16x oversampling and majority voting.
// Assumes tick16 is a one-cycle pulse at sixteen times the bit rate.
module sp_async_rx
	import sp_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic tick16,
	input wire logic enable,
	input wire logic eleven_bit,
	input wire logic rxd,
	output logic frame_done,
	output logic [7:0] frame_data,
	output logic frame_ninth,
	output logic frame_stop
);

	sp_rx_state_t state_reg;
	logic [3:0] cnt_reg;
	logic [3:0] bit_idx_reg;
	logic line_reg;
	logic samp_a_reg;
	logic samp_b_reg;

	// Decision point, the voted bit and the index of the stop bit.
	wire logic decide = (state_reg == SP_RX_FRAME) && (cnt_reg == SP_SAMPLE_C);
	wire logic bit_val = sp_majority(samp_a_reg, samp_b_reg, rxd);
	wire logic [3:0] stop_idx = eleven_bit ? SP_FRAME_ELEVEN - 4'h1 : SP_FRAME_TEN - 4'h1;
	wire logic falling = line_reg && !rxd;

	// All but the clearing of the one-clock frame_done pulse advances on the oversampling tick only.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= SP_RX_HUNT;
			cnt_reg <= 4'h0;
			bit_idx_reg <= 4'h0;
			line_reg <= 1'b1;
			samp_a_reg <= 1'b1;
			samp_b_reg <= 1'b1;
			frame_done <= 1'b0;
			frame_data <= 8'h00;
			frame_ninth <= 1'b0;
			frame_stop <= 1'b0;
		end else begin
			frame_done <= 1'b0;
			if (tick16) begin
				line_reg <= rxd;
				cnt_reg <= cnt_reg + 4'h1;
				if (state_reg == SP_RX_HUNT) begin
					if (enable && falling) begin
						state_reg <= SP_RX_FRAME;
						cnt_reg <= 4'h0; // Realign bit slices to the edge.
						bit_idx_reg <= 4'h0;
					end
				end else begin
					if (cnt_reg == SP_SAMPLE_A)
						samp_a_reg <= rxd;
					if (cnt_reg == SP_SAMPLE_B)
						samp_b_reg <= rxd;
					if (decide) begin
						bit_idx_reg <= bit_idx_reg + 4'h1;
						if (bit_idx_reg == 4'h0 && bit_val) begin
							state_reg <= SP_RX_HUNT; // False start, hunt again.
						end else if (bit_idx_reg == stop_idx) begin
							frame_stop <= bit_val;
							frame_done <= 1'b1;
							state_reg <= SP_RX_HUNT; // Back to hunting mid stop bit.
						end else if (bit_idx_reg <= SP_M0_BITS) begin
							frame_data <= {bit_val, frame_data[7:1]};
						end else begin
							frame_ninth <= bit_val;
						end
					end
				end
			end
		end
	end

endmodule

// ===== tb/sp_serial_port_asserts.sv
// Concurrent checks of the mode-0 shift clock and data-line ownership.
// Assumes the bench master offers address and data together on writes.
module sp_serial_port_asserts
	import sp_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [SP_ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic rxd_oe,
	input wire logic txd
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [7:0] ctrl_reg;
	logic [3:0] rx_cnt_reg;
	// Decoded write acceptance; a split address and data write is not tracked.
	wire wr_take = awvalid && awready && wvalid && wready && wstrb[0];
	wire ctl_wr = wr_take && awaddr == SP_OFS_CONTROL;
	wire buf_wr = wr_take && awaddr == SP_OFS_BUFFER;
	wire m0 = ctrl_reg[1:0] == 2'h0;
	wire fast = m0 && ctrl_reg[SP_CTRL_SPEED];
	wire slow = m0 && !ctrl_reg[SP_CTRL_SPEED];
	// Shadow of the control register, updated when the write is accepted.
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ctrl_reg <= 8'h00;
		else if (ctl_wr)
			ctrl_reg <= wdata[7:0];
	end
	// Rising shift-clock edges of a receive; any control write starts a new count.
	always_ff @(posedge aclk) begin
		if (!aresetn || ctl_wr)
			rx_cnt_reg <= 4'h0;
		else if (m0 && !rxd_oe && $rose(txd) && rx_cnt_reg < 4'h8)
			rx_cnt_reg <= rx_cnt_reg + 4'h1;
	end
	property p_tx_start;
		buf_wr && m0 && !ctrl_reg[SP_CTRL_RX_EN] && !rxd_oe |-> ##[1:4] rxd_oe;
	endproperty
	property p_oe_mode0;
		rxd_oe |-> m0;
	endproperty
	property p_fast_high;
		fast && $rose(txd) |=> txd;
	endproperty
	property p_slow_high;
		slow && $rose(txd) |=> txd[*5];
	endproperty
	property p_fast_low;
		fast && $fell(txd) |=> !txd ##1 txd;
	endproperty
	property p_slow_low;
		slow && $fell(txd) |=> !txd[*5] ##1 txd;
	endproperty
	property p_idle_clock;
		m0 && !ctrl_reg[SP_CTRL_RX_EN] && !rxd_oe |-> txd;
	endproperty
	property p_rx_hold;
		rx_cnt_reg == 4'h8 |-> txd;
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("Transfer did not start.");
	a_oe_mode0: assert property (p_oe_mode0) else $error("Data driven off mode 0.");
	a_fast_high: assert property (p_fast_high) else $error("Fast period wrong.");
	a_slow_high: assert property (p_slow_high) else $error("Slow period wrong.");
	a_fast_low: assert property (p_fast_low) else $error("Fast low time wrong.");
	a_slow_low: assert property (p_slow_low) else $error("Slow low time wrong.");
	a_idle_clock: assert property (p_idle_clock) else $error("Clock while disabled.");
	a_rx_hold: assert property (p_rx_hold) else $error("Clock after receive done.");
	c_fast: cover property (fast && $fell(txd));
	c_slow: cover property (slow && $fell(txd));
	c_rx_done: cover property (rx_cnt_reg == 4'h8);
endmodule

bind sp_serial_port sp_serial_port_asserts u_chk (.aclk, .aresetn, .awaddr, .awvalid,
	.awready, .wdata, .wstrb, .wvalid, .wready, .rxd_oe, .txd);

// ===== tb/sp_partner.sv
// Far-side device: a mode-0 shift slave and an asynchronous frame sender.
// Assumes the bench resolves the data line and returns it on line.
module sp_partner (
	input wire logic aclk,
	input wire logic txd,
	input wire logic line,
	output logic drive,
	output logic [7:0] cap
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] sbyte = 8'h00;
	logic txd_q = 1'h1;
	bit sync_on = 1'b0;
	int falls = 8;
	int rises = 8;
	initial drive = 1'h1;
	initial cap = 8'h00;
	// New data after each falling shift-clock edge, capture after each rise.
	always @(posedge aclk) begin
		txd_q <= txd;
		if (sync_on && txd_q && !txd && falls < 8) begin
			drive <= sbyte[falls];
			falls <= falls + 1;
		end
		if (sync_on && rises >= 8)
			drive <= ~drive; // Released line must not keep the last bit.
		if (!txd_q && txd) begin
			cap <= {line, cap[7:1]};
			rises <= rises + 1;
		end
	end
	task automatic arm(input logic [7:0] b);
		sbyte = b;
		falls = 0;
		rises = 0;
		sync_on = 1'b1;
	endtask
	// The line rests at the mark level once a frame is sent.
	task automatic send(input logic [10:0] bits, input int n, input int clks);
		sync_on = 1'b0;
		for (int i = 0; i < n; i++) begin
			drive <= bits[i];
			repeat (clks) @(posedge aclk);
		end
		drive <= 1'h1;
	endtask
endmodule

// ===== tb/tb_serial_port_modes_0_to_2.sv
// Self-checking bench of the serial port against a behavioural frame model.
// Assumes the package, the partner model and the checker are compiled first.
module tb_serial_port_modes_0_to_2
	import sp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [3:0] awaddr = 4'h0;
	logic [3:0] araddr = 4'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic ovf = 1'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, rxd_out, rxd_oe, txd, p_drive, rxd_in;
	logic [1:0] bresp, rresp, last_resp;
	logic [31:0] rdata;
	logic [7:0] cap;
	int mismatches = 0;
	int comparisons = 0;
	always #25 aclk = ~aclk;
	// Timer overflow every second clock; the device owns the line only when enabled.
	always @(posedge aclk) ovf <= ~ovf;
	assign rxd_in = rxd_oe ? rxd_out : p_drive;
	sp_serial_port u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .timer1_overflow(ovf), .rxd_in, .rxd_out, .rxd_oe, .txd);
	sp_partner u_partner (.aclk, .txd, .line(rxd_in), .drive(p_drive), .cap);
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Write master: address and data offered together, each released when taken.
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bit aw_done, w_done;
		aw_done = 0;
		w_done = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= 4'hf;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (!aw_done && awready === 1'h1) begin
				aw_done = 1;
				awvalid <= 1'h0;
			end
			if (!w_done && wready === 1'h1) begin
				w_done = 1;
				wvalid <= 1'h0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'h1);
		last_resp = bresp;
		bready <= 1'h0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge aclk); while (arready !== 1'h1);
		arvalid <= 1'h0;
		do @(posedge aclk); while (rvalid !== 1'h1);
		d = rdata;
		last_resp = rresp;
		rready <= 1'h0;
	endtask
	task automatic poll(input int bitn);
		logic [31:0] d;
		int n;
		n = 0;
		do begin
			rd(SP_OFS_CONTROL, d);
			n++;
		end while (d[bitn] !== 1'h1 && n < 400);
		chk({31'h0, d[bitn]}, 32'h1);
	endtask
	// Samples a frame on txd at mid-bit; a lost start bit shows as a wrong frame.
	task automatic catch_frame(input int n, input int bc, output logic [31:0] got);
		int t;
		t = 0;
		got = 32'h0;
		while (txd !== 1'h0 && t < 2000) begin
			@(posedge aclk);
			t++;
		end
		repeat (bc / 2) @(posedge aclk);
		for (int i = 0; i < n; i++) begin
			got[i] = txd;
			repeat (bc) @(posedge aclk);
		end
	endtask
	function automatic logic [31:0] frame(input int d, input int m, input int n9, input int st);
		if (m == 1)
			return (st << 9) | (d << 1);
		return (st << 10) | (n9 << 9) | (d << 1);
	endfunction
	// Run limit: 40000 cycles; the sequence needs under 10000 cycles.
	initial begin
		#2000000;
		mismatches++;
		summarize();
	end
	initial begin
		logic [31:0] d;
		int b, row, m, dr, ld, st, n9, exp_buf, exp_rb8;
		int rows[7] = '{8'h12, 8'h1d, 8'h04, 8'h13, 8'h32, 8'h52, 8'h9b};
		exp_rb8 = 0;
		void'($urandom(32'ha34b));
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		// All registers start at zero; the fourth word is unmapped.
		for (int a = 0; a < 16; a += 4) begin
			rd(a[3:0], d);
			chk(d, 32'h0);
			chk({30'h0, last_resp}, (a == 12) ? 32'h2 : 32'h0);
		end
		wr(4'hc, 8'hff);
		chk({30'h0, last_resp}, 32'h2);
		// Mode-0 transmit then receive at both shift rates.
		for (int s = 0; s < 2; s++) begin
			b = $urandom_range(255);
			wr(SP_OFS_CONTROL, {5'h0, s[0], 2'h0});
			wr(SP_OFS_BUFFER, b[7:0]);
			chk({30'h0, last_resp}, 32'h0);
			poll(SP_CTRL_TX_DONE);
			chk({24'h0, cap}, b);
			b = $urandom_range(255);
			u_partner.arm(b[7:0]);
			wr(SP_OFS_CONTROL, {4'h0, 1'h1, s[0], 2'h0});
			poll(SP_CTRL_RX_DONE);
			wr(SP_OFS_CONTROL, {5'h10, s[0], 2'h0});
			rd(SP_OFS_BUFFER, d);
			chk(d, b);
			exp_buf = b;
		end
		u_partner.send(11'h7ff, 1, 1);
		// Asynchronous transmit in both frame modes at both rates.
		for (int k = 0; k < 4; k++) begin
			m = 1 + k / 2;
			dr = k % 2;
			b = $urandom_range(255);
			wr(SP_OFS_POWER, dr[7:0]);
			wr(SP_OFS_CONTROL, {3'h0, dr[0], 2'h0, m[1:0]});
			wr(SP_OFS_BUFFER, b[7:0]);
			catch_frame(m + 9, dr ? 32 : 64, d);
			chk(d, frame(b, m, dr, 1));
			poll(SP_CTRL_TX_DONE);
		end
		// Rows: mode 2, double rate, speed, ninth, stop, glitch, disabled, flag kept.
		foreach (rows[i]) begin
			row = rows[i];
			m = row[0] ? 2 : 1;
			dr = row[1];
			n9 = row[3];
			st = row[4];
			b = $urandom_range(255);
			wr(SP_OFS_POWER, dr[7:0]);
			wr(SP_OFS_CONTROL, {row[7], 3'h0, !row[6], row[2], m[1:0]});
			d = frame(b, m, n9, st);
			if (row[5])
				u_partner.send(11'h0, 1, 4);
			else
				u_partner.send(d[10:0], m + 9, dr ? 32 : 64);
			repeat (64) @(posedge aclk);
			ld = !row[5] && !row[6] && !row[7] && (!row[2] || st);
			if (ld) begin
				exp_buf = b;
				exp_rb8 = (m == 1) ? st : n9;
			end
			rd(SP_OFS_CONTROL, d);
			chk({30'h0, d[7], d[5]}, {30'h0, ld || row[7], exp_rb8[0]});
			rd(SP_OFS_BUFFER, d);
			chk(d, exp_buf);
		end
		summarize();
	end
endmodule
